// ==== src/fbmc_pkg.sv ====
// Constants and types shared by the flash bus mode host controller.
// ============================================================
// Behaviour
// RQ1: Read: select low, gate low, strobe high; device drives data.
// RQ2: Write: select and strobe low, gate high; host drives data.
// RQ3: Device command register latches write command, address and data.
// RQ4: Reset low for minimum pulse aborts, floats outputs, ignores cycles.
// RQ5: Hardware reset returns the device to array read.
// RQ6: Reset during program or erase keeps done flag low until reset finishes.
// RQ7: Idle reset settles; host waits reset-to-read delay before reading.
// RQ8: Power-up starts the device in array read.
// RQ9: Array reads need no command until a write changes the command register.
// RQ10: Erase targets sectors chosen by the upper address bits.
// RQ11: Identification command makes reads return internal codes.
// RQ12: Identification codes readable by elevated pin or software sequence.
// RQ13: Id read: id pin elevated, bit1 low, bit0 selects device code.
// RQ14: Protect verify: sector bits, bit1 high, reads 00H or 01H.
// RQ15: Host reissues a program or erase aborted by hardware reset; this controller only flags it on RSP_ABORTED_BUSY.
// RQ16: System reset may drive the flash reset to fetch boot code.
// RQ17: Device data pins float whenever output gate or chip select is high.
// RQ18: Address latched on later falling edge, data on earlier rising edge.
// RQ19: Wrong or out-of-order writes abandon the sequence and return to read.
// RQ20: Elevated reset level temporarily unprotects all sectors.
// RQ21: Protect: reset elevated, select low, gate high, bits1:0 10, bit6 dir.
package fbmc_pkg;

  localparam int CLK_MHZ = 100;
  localparam int ADDR_W  = 19;
  localparam int DATA_W  = 8;

  // ============================================================
  // Timing figures in ns and derived cycle counts.
  localparam int T_ACCESS_NS      = 70;
  localparam int T_WE_PULSE_NS    = 50;
  localparam int T_WR_HOLD_NS     = 20;
  localparam int T_RESET_PULSE_NS = 500;
  localparam int T_RESET_READ_NS  = 50;
  localparam int T_READY_BUSY_NS  = 20000;
  localparam int T_HV_SETUP_NS    = 4000;
  localparam int T_PROT_PULSE_NS  = 100000;
  localparam int SYNC_STAGES      = 2;

  function automatic int ns_up(input int ns);
    int c;
    c = (ns * CLK_MHZ + 999) / 1000;
    return (c < 1) ? 1 : c;
  endfunction

  localparam int ACCESS_CYC      = ns_up(T_ACCESS_NS) + SYNC_STAGES;
  localparam int WE_PULSE_CYC    = ns_up(T_WE_PULSE_NS);
  localparam int WR_HOLD_CYC     = ns_up(T_WR_HOLD_NS);
  localparam int RESET_PULSE_CYC = ns_up(T_RESET_PULSE_NS);
  localparam int RESET_READ_CYC  = ns_up(T_RESET_READ_NS);
  localparam int READY_BUSY_CYC  = (T_READY_BUSY_NS * CLK_MHZ) / 1000;
  localparam int HV_SETUP_CYC    = ns_up(T_HV_SETUP_NS);
  localparam int PROT_PULSE_CYC  = ns_up(T_PROT_PULSE_NS);

  // ============================================================
  // Address bit positions.
  localparam int SECTOR_LSB  = 13;
  localparam int PROT_DIR_BIT = 6;
  localparam int ID_SEL1_BIT = 1;
  localparam int ID_SEL0_BIT = 0;

  typedef enum logic [2:0] {
    FBMC_OP_READ,
    FBMC_OP_WRITE,
    FBMC_OP_ID_READ,
    FBMC_OP_PROTECT,
    FBMC_OP_UNPROTECT,
    FBMC_OP_RESET
  } fbmc_op_t;

  typedef struct packed {
    fbmc_op_t            op;
    logic [ADDR_W-1:0]   addr;
    logic [DATA_W-1:0]   data;
  } fbmc_cmd_t;

  typedef struct packed {
    logic ce_n;
    logic oe_n;
    logic we_n;
  } fbmc_strobe_t;

endpackage

// ==== src/fbmc_sync.sv ====
// Two-stage synchroniser, one chain per bit.
`timescale 1ns/10ps
`default_nettype none
module fbmc_sync
  import fbmc_pkg::*;
#(
  parameter int WIDTH = 1
)
(
  input  wire logic             clk,
  input  wire logic             srst,
  input  wire logic [WIDTH-1:0] async_in,
  output var  logic [WIDTH-1:0] sync_out
);

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++)
    begin : g_bit
      logic meta_reg;
      logic stable_reg;
      always_ff @(posedge clk)
      begin
        if (srst)
        begin
          meta_reg   <= 1'b0;
          stable_reg <= 1'b0;
        end
        else
        begin
          meta_reg   <= async_in[i];
          stable_reg <= meta_reg;
        end
      end
      assign sync_out[i] = stable_reg;
    end
  endgenerate

endmodule
`default_nettype wire

// ==== src/fbmc_host.sv ====
// Host-side controller driving the parallel flash bus pins.
`timescale 1ns/10ps
`default_nettype none
module fbmc_host
  import fbmc_pkg::*;
#(
  parameter int PROT_PULSE_CYCLES = PROT_PULSE_CYC,
  parameter int READY_CYCLES      = READY_BUSY_CYC
)
(
  input  wire logic              CLOCK,
  input  wire logic              SRST,
  input  wire logic              CMD_VALID,
  output var  logic              CMD_READY,
  input  wire fbmc_cmd_t         CMD,
  output var  logic              RSP_VALID,
  output var  logic [DATA_W-1:0] RSP_DATA,
  output var  logic              RSP_ABORTED_BUSY,
  output var  logic              FL_CE_N,
  output var  logic              FL_OE_N,
  output var  logic              FL_WE_N,
  output var  logic              FL_RESET_N,
  output var  logic              FL_RESET_ELEVATED,
  output var  logic              FL_ID_ELEVATED,
  output var  logic [ADDR_W-1:0] FL_ADDR,
  output var  logic [DATA_W-1:0] FL_DQ_O,
  output var  logic              FL_DQ_OE,
  input  wire logic [DATA_W-1:0] FL_DQ_I,
  input  wire logic              FL_OP_DONE_FLAG
);

  // ============================================================
  // States and storage.
  typedef enum logic [3:0] {
    S_IDLE,
    S_RD_WAIT,
    S_WR_SETUP,
    S_WR_PULSE,
    S_WR_HOLD,
    S_HV_SETUP,
    S_RST_LOW,
    S_RST_BUSY,
    S_RST_READ,
    S_END
  } fbmc_state_t;

  fbmc_state_t       state_reg;
  fbmc_state_t       state_next;
  logic [15:0]       cnt_reg;
  logic [15:0]       cnt_next;
  fbmc_cmd_t         cmd_reg;
  fbmc_strobe_t      strobe_reg;
  fbmc_strobe_t      strobe_next;
  logic              rst_n_reg;
  logic              rst_hv_reg;
  logic              id_hv_reg;
  logic [ADDR_W-1:0] addr_reg;
  logic              dq_oe_reg;
  logic              rsp_valid_reg;
  logic [DATA_W-1:0] rsp_data_reg;
  logic              aborted_reg;
  logic              ready_reg;
  logic [DATA_W-1:0] dq_sync;
  logic              done_sync;

  // ============================================================
  // Pin input synchronisers.
  fbmc_sync #(.WIDTH(DATA_W + 1)) u_sync (
    .clk      (CLOCK),
    .srst     (SRST),
    .async_in ({FL_OP_DONE_FLAG, FL_DQ_I}),
    .sync_out ({done_sync, dq_sync})
  );

  // ============================================================
  // Decode of the accepted command.
  wire             take_cmd   = ready_reg && CMD_VALID;
  wire             cnt_zero   = (cnt_reg == 16'h0000);
  wire             is_prot    = (CMD.op == FBMC_OP_PROTECT) ||
                                (CMD.op == FBMC_OP_UNPROTECT);
  wire             is_hv_prot = (cmd_reg.op == FBMC_OP_PROTECT) ||
                                (cmd_reg.op == FBMC_OP_UNPROTECT);
  wire             unprot_dir = (CMD.op == FBMC_OP_UNPROTECT);
  wire [ADDR_W-1:0] prot_addr = {CMD.addr[ADDR_W-1:PROT_DIR_BIT+1],
                                 unprot_dir,
                                 CMD.addr[PROT_DIR_BIT-1:ID_SEL1_BIT+1],
                                 2'h2}; // [RQ21] [RQ10]
  wire [ADDR_W-1:0] addr_sel  = is_prot ? prot_addr : CMD.addr;
  wire [15:0] pulse_cyc = is_hv_prot ? 16'(PROT_PULSE_CYCLES - 1)
                                     : 16'(WE_PULSE_CYC - 1);

  // ============================================================
  // Next state and counter.
  always_comb
  begin
    state_next  = state_reg;
    cnt_next    = cnt_zero ? 16'h0000 : 16'(cnt_reg - 16'h0001);
    strobe_next = strobe_reg;
    unique case (state_reg)
      S_IDLE:
      begin
        strobe_next = '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1};
        if (take_cmd)
        begin
          unique case (CMD.op)
            FBMC_OP_READ, FBMC_OP_ID_READ: // [RQ9]
            begin
              state_next  = S_RD_WAIT;
              cnt_next    = 16'(ACCESS_CYC - 1);
              strobe_next = '{ce_n: 1'b0, oe_n: 1'b0, we_n: 1'b1}; // [RQ1]
            end
            FBMC_OP_WRITE: // [RQ19]
            begin
              state_next  = S_WR_SETUP;
              cnt_next    = 16'h0000;
              strobe_next = '{ce_n: 1'b0, oe_n: 1'b1, we_n: 1'b1}; // [RQ2]
            end
            FBMC_OP_PROTECT, FBMC_OP_UNPROTECT:
            begin
              state_next  = S_HV_SETUP;
              cnt_next    = 16'(HV_SETUP_CYC - 1);
              strobe_next = '{ce_n: 1'b0, oe_n: 1'b1, we_n: 1'b1}; // [RQ21]
            end
            FBMC_OP_RESET:
            begin
              state_next = S_RST_LOW;
              cnt_next   = 16'(RESET_PULSE_CYC - 1); // [RQ4]
            end
            default:
            begin
              state_next = S_IDLE;
            end
          endcase
        end
      end
      S_RD_WAIT:
        if (cnt_zero)
        begin
          state_next  = S_END;
          strobe_next = '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1}; // [RQ17]
        end
      S_WR_SETUP, S_HV_SETUP:
        if (cnt_zero)
        begin
          state_next  = S_WR_PULSE;
          cnt_next    = pulse_cyc;
          strobe_next = '{ce_n: 1'b0, oe_n: 1'b1, we_n: 1'b0}; // [RQ18]
        end
      S_WR_PULSE:
        if (cnt_zero)
        begin
          state_next  = S_WR_HOLD;
          cnt_next    = 16'(WR_HOLD_CYC - 1);
          strobe_next = '{ce_n: 1'b0, oe_n: 1'b1, we_n: 1'b1}; // [RQ18]
        end
      S_WR_HOLD:
        if (cnt_zero)
        begin
          state_next  = S_END;
          strobe_next = '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1};
        end
      S_RST_LOW:
        if (cnt_zero)
        begin
          state_next = S_RST_BUSY;
          cnt_next   = 16'(READY_CYCLES - 1);
        end
      S_RST_BUSY:
        if (done_sync || cnt_zero) // [RQ6]
        begin
          state_next = S_RST_READ;
          cnt_next   = 16'(RESET_READ_CYC - 1); // [RQ7]
        end
      S_RST_READ:
        if (cnt_zero)
        begin
          state_next = S_END; // [RQ5]
        end
      S_END:
        state_next = S_IDLE;
    endcase
  end

  // ============================================================
  // Registered state, strobes and pin levels.
  always_ff @(posedge CLOCK)
  begin
    if (SRST)
    begin
      state_reg  <= S_IDLE; // [RQ8]
      cnt_reg    <= 16'h0000;
      strobe_reg <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1};
      ready_reg  <= 1'b0;
    end
    else
    begin
      state_reg  <= state_next;
      cnt_reg    <= cnt_next;
      strobe_reg <= strobe_next;
      ready_reg  <= (state_next == S_IDLE);
    end
  end

  always_ff @(posedge CLOCK)
  begin
    if (SRST)
    begin
      cmd_reg    <= '0;
      addr_reg   <= '0;
      dq_oe_reg  <= 1'b0;
      rst_n_reg  <= 1'b1;
      rst_hv_reg <= 1'b0;
      id_hv_reg  <= 1'b0;
    end
    else if (take_cmd)
    begin
      cmd_reg    <= CMD; // [RQ3]
      addr_reg   <= addr_sel;
      dq_oe_reg  <= (CMD.op == FBMC_OP_WRITE) || is_prot; // [RQ2]
      rst_n_reg  <= (CMD.op != FBMC_OP_RESET); // [RQ4] [RQ16]
      rst_hv_reg <= is_prot; // [RQ21]
      id_hv_reg  <= (CMD.op == FBMC_OP_ID_READ); // [RQ13] [RQ12]
    end
    else
    begin
      if (state_next == S_END && state_reg != S_RST_READ)
      begin
        dq_oe_reg  <= 1'b0;
        rst_hv_reg <= 1'b0;
        id_hv_reg  <= 1'b0;
      end
      if (state_reg == S_RST_LOW && cnt_zero)
      begin
        rst_n_reg <= 1'b1;
      end
    end
  end

  // ============================================================
  // Answers to the user side.
  always_ff @(posedge CLOCK)
  begin
    if (SRST)
    begin
      rsp_valid_reg <= 1'b0;
      rsp_data_reg  <= 8'h00;
      aborted_reg   <= 1'b0;
    end
    else
    begin
      rsp_valid_reg <= (state_reg == S_END);
      if (state_reg == S_RD_WAIT && cnt_zero)
      begin
        rsp_data_reg <= dq_sync; // [RQ1] [RQ14] [RQ11]
      end
      if (take_cmd && CMD.op == FBMC_OP_RESET)
      begin
        aborted_reg <= !done_sync; // [RQ15]
      end
    end
  end

  assign CMD_READY         = ready_reg;
  assign RSP_VALID         = rsp_valid_reg;
  assign RSP_DATA          = rsp_data_reg;
  assign RSP_ABORTED_BUSY  = aborted_reg;
  assign FL_CE_N           = strobe_reg.ce_n;
  assign FL_OE_N           = strobe_reg.oe_n;
  assign FL_WE_N           = strobe_reg.we_n;
  assign FL_RESET_N        = rst_n_reg;
  assign FL_RESET_ELEVATED = rst_hv_reg; // [RQ20]
  assign FL_ID_ELEVATED    = id_hv_reg;
  assign FL_ADDR           = addr_reg;
  assign FL_DQ_O           = cmd_reg.data;
  assign FL_DQ_OE          = dq_oe_reg;

endmodule
`default_nettype wire

// ==== verification/fbmc_host_assertions.sv ====
// Checker on the flash pins and the request port of the host controller.
`timescale 1ns/10ps
`default_nettype none
module fbmc_host_assertions
  import fbmc_pkg::*;
(
  input  wire logic              CLOCK,
  input  wire logic              SRST,
  input  wire logic              CMD_VALID,
  input  wire logic              CMD_READY,
  input  wire fbmc_cmd_t         CMD,
  input  wire logic              RSP_VALID,
  input  wire logic              FL_CE_N,
  input  wire logic              FL_OE_N,
  input  wire logic              FL_WE_N,
  input  wire logic              FL_RESET_N,
  input  wire logic              FL_RESET_ELEVATED,
  input  wire logic              FL_ID_ELEVATED,
  input  wire logic [ADDR_W-1:0] FL_ADDR,
  input  wire logic [DATA_W-1:0] FL_DQ_O,
  input  wire logic              FL_DQ_OE
);
  // ============================================================
  // Pin relations.
  int low_cnt_reg;
  always_ff @(posedge CLOCK)
  begin
    if (SRST || FL_RESET_N)
      low_cnt_reg <= 0;
    else
      low_cnt_reg <= low_cnt_reg + 1;
  end
  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (SRST);
  sequence take_rd;
    CMD_VALID && CMD_READY && CMD.op == FBMC_OP_READ;
  endsequence
  sequence take_wr;
    CMD_VALID && CMD_READY && CMD.op == FBMC_OP_WRITE;
  endsequence
  a_read_cycle: assert property
    (take_rd |=> ##[0:1] (!FL_CE_N && !FL_OE_N)[*8] ##[1:4] RSP_VALID)
    else $error("Read strobes or answer out of place.");
  a_write_pulse: assert property
    (take_wr |=> ##[1:3] $fell(FL_WE_N) ##0 (!FL_WE_N)[*5] ##1 FL_WE_N)
    else $error("Write strobe pulse has the wrong length.");
  a_write_pins: assert property
    (!FL_WE_N |-> !FL_CE_N && FL_OE_N && FL_DQ_OE)
    else $error("Write strobe low without select or data drive.");
  a_read_bus: assert property
    (!FL_OE_N |-> FL_WE_N && !FL_DQ_OE)
    else $error("Data driven by host while output gate is low.");
  a_latch_stable: assert property
    (!FL_WE_N && !$past(FL_WE_N) |-> $stable(FL_ADDR) && $stable(FL_DQ_O))
    else $error("Address or data moved during a write pulse.");
  a_reset_pulse: assert property
    ($rose(FL_RESET_N) |-> low_cnt_reg >= RESET_PULSE_CYC)
    else $error("Reset pulse shorter than the minimum.");
  a_reset_read: assert property
    ($rose(FL_RESET_N) |-> FL_OE_N [*5])
    else $error("Read started before the reset-to-read delay.");
  a_reset_quiet: assert property
    (!FL_RESET_N |-> FL_CE_N && FL_WE_N && FL_OE_N)
    else $error("Bus cycle while reset is low.");
  a_id_pins: assert property
    (FL_ID_ELEVATED |-> FL_WE_N && FL_RESET_N && !FL_RESET_ELEVATED)
    else $error("Elevated id pin outside an id read.");
  a_protect_pins: assert property
    (FL_RESET_ELEVATED && !FL_WE_N |-> FL_ADDR[1] && !FL_ADDR[0])
    else $error("Protect pulse with wrong select bits.");
  a_one_op: assert property
    (CMD_VALID && CMD_READY |=> !CMD_READY)
    else $error("Ready stayed high after a request was taken.");
endmodule
bind fbmc_host fbmc_host_assertions fbmc_host_assertions_inst (
  .CLOCK             (CLOCK),
  .SRST              (SRST),
  .CMD_VALID         (CMD_VALID),
  .CMD_READY         (CMD_READY),
  .CMD               (CMD),
  .RSP_VALID         (RSP_VALID),
  .FL_CE_N           (FL_CE_N),
  .FL_OE_N           (FL_OE_N),
  .FL_WE_N           (FL_WE_N),
  .FL_RESET_N        (FL_RESET_N),
  .FL_RESET_ELEVATED (FL_RESET_ELEVATED),
  .FL_ID_ELEVATED    (FL_ID_ELEVATED),
  .FL_ADDR           (FL_ADDR),
  .FL_DQ_O           (FL_DQ_O),
  .FL_DQ_OE          (FL_DQ_OE)
);
`default_nettype wire

// ==== verification/fbmc_flash_model.sv ====
// Behavioural flash device on the far side of the host controller.
`timescale 1ns/10ps
`default_nettype none
module fbmc_flash_model
  import fbmc_pkg::*;
#(
  parameter logic [DATA_W-1:0] MFR_CODE = 8'h11, // Arbitrary value.
  parameter logic [DATA_W-1:0] DEV_CODE = 8'h22, // Arbitrary value.
  parameter int                BUSY_NS  = 300
)
(
  input  wire logic              ce_n,
  input  wire logic              oe_n,
  input  wire logic              we_n,
  input  wire logic              reset_n,
  input  wire logic              reset_hv,
  input  wire logic              id_hv,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [DATA_W-1:0] din,
  input  wire logic              busy_req,
  output var  logic [DATA_W-1:0] dq,
  output var  logic              done
);
  // ============================================================
  // Array, protection bits and status.
  logic [DATA_W-1:0] mem [16];
  logic [63:0]       prot = '0;
  logic [DATA_W-1:0] last = 8'h00;
  logic [ADDR_W-1:0] wa;
  logic              busy = 1'b0;
  wire               drv = !ce_n && !oe_n && we_n && reset_n;
  wire  [DATA_W-1:0] code = addr[0] ? DEV_CODE : MFR_CODE;
  wire  [DATA_W-1:0] idv = addr[1] ? {7'h00, prot[addr[18:13]]}
                                   : code;
  wire  [DATA_W-1:0] rd = id_hv ? idv : mem[addr[3:0]];
  initial
    for (int i = 0; i < 16; i++)
      mem[i] = 8'hA0 + 8'(i);
  assign dq = drv ? rd : ~last;
  assign done = !busy;
  always @(drv or rd)
    if (drv)
      last = rd;
  always @(negedge we_n)
  begin
    wa = addr;
    if (reset_hv && !ce_n && oe_n && addr[1:0] == 2'b10)
      prot[addr[18:13]] = !addr[6];
  end
  always @(posedge we_n)
    if (!ce_n && oe_n && reset_n && !reset_hv)
      mem[wa[3:0]] = din;
  always @(posedge busy_req)
    busy = 1'b1;
  always @(posedge reset_n)
    if (busy)
      busy <= #(BUSY_NS) 1'b0;
endmodule
`default_nettype wire

// ==== verification/fbmc_host_test.sv ====
// Self-checking bench for the flash bus host controller.
`timescale 1ns/10ps
`default_nettype none
module fbmc_host_test
  import fbmc_pkg::*;
;
  // ============================================================
  // Stimulus, device model and result queue.
  localparam logic [7:0] MFR = 8'h3C; // Arbitrary value.
  localparam logic [7:0] DEV = 8'hC3; // Arbitrary value.
  logic              clk = 1'b0;
  logic              srst = 1'b1;
  logic              vld = 1'b0;
  logic              busy_req = 1'b0;
  fbmc_cmd_t         cmd = '0;
  logic              rdy, rsp, abt, ce_n, oe_n, we_n, rst_n, rst_hv, id_hv;
  logic              dq_oe, done;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] rdata, dq_o, dev_q, d;
  wire  [DATA_W-1:0] bus = dq_oe ? dq_o : dev_q;
  logic [10:0]       notes [$];
  logic [10:0]       nt;
  int                errors = 0;
  int                n_checks = 0;
  int                i, a, sa;
  time               t0;
  logic              waited;
  always #5 clk = ~clk;
  fbmc_host #(.PROT_PULSE_CYCLES(20), .READY_CYCLES(100)) fbmc_host_inst (
    .CLOCK(clk), .SRST(srst), .CMD_VALID(vld), .CMD_READY(rdy), .CMD(cmd),
    .RSP_VALID(rsp), .RSP_DATA(rdata), .RSP_ABORTED_BUSY(abt),
    .FL_CE_N(ce_n), .FL_OE_N(oe_n), .FL_WE_N(we_n), .FL_RESET_N(rst_n),
    .FL_RESET_ELEVATED(rst_hv), .FL_ID_ELEVATED(id_hv), .FL_ADDR(addr),
    .FL_DQ_O(dq_o), .FL_DQ_OE(dq_oe), .FL_DQ_I(bus),
    .FL_OP_DONE_FLAG(done));
  fbmc_flash_model #(.MFR_CODE(MFR), .DEV_CODE(DEV)) fbmc_flash_model_inst (
    .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .reset_n(rst_n), .reset_hv(rst_hv),
    .id_hv(id_hv), .addr(addr), .din(bus), .busy_req(busy_req), .dq(dev_q),
    .done(done));
  task automatic check(input string what, input logic [7:0] e,
                       input logic [7:0] s);
    n_checks++;
    if (s !== e)
    begin
      errors++;
      $display("wrong value %s expected %h seen %h", what, e, s);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic run(input fbmc_op_t op, input int ad,
                     input logic [10:0] note);
    int n;
    notes.push_back(note);
    @(negedge clk);
    vld = 1'b1;
    cmd = '{op, ad[ADDR_W-1:0], note[7:0]};
    for (n = 0; n < 100 && rdy !== 1'b1; n++)
      @(negedge clk);
    if (rdy !== 1'b1)
      errors++;
    @(negedge clk);
    vld = 1'b0;
    for (n = 0; n < 30000 && rsp !== 1'b1; n++)
      @(negedge clk);
    if (rsp !== 1'b1)
      errors++;
    @(negedge clk);
  endtask
  always @(negedge clk)
  begin
    if (rsp === 1'b1)
    begin
      nt = notes.pop_front();
      if (nt[10])
        check("read data", nt[7:0], rdata);
      if (nt[9])
        check("aborted flag", {7'h00, nt[8]}, {7'h00, abt});
    end
  end
  initial
  begin
    #300000;
    errors++;
    report_and_stop();
  end
  initial
  begin
    a = $urandom(30);
    repeat (10) @(negedge clk);
    srst = 1'b0;
    repeat (2) @(negedge clk);
    for (i = 0; i < 4; i++)
      run(FBMC_OP_READ, i, {3'b100, 8'hA0 + i[7:0]});
    for (i = 0; i < 4; i++)
    begin
      a = $urandom % 524288;
      d = 8'($urandom);
      run(FBMC_OP_WRITE, a, {3'b000, d});
      run(FBMC_OP_READ, a, {3'b100, d});
    end
    run(FBMC_OP_ID_READ, 0, {3'b100, MFR});
    run(FBMC_OP_ID_READ, 1, {3'b100, DEV});
    sa = 3 << 13;
    run(FBMC_OP_ID_READ, sa + 2, {3'b100, 8'h00});
    run(FBMC_OP_PROTECT, sa, {3'b000, 8'h00});
    run(FBMC_OP_ID_READ, sa + 2, {3'b100, 8'h01});
    run(FBMC_OP_ID_READ, sa + 8194, {3'b100, 8'h00});
    run(FBMC_OP_UNPROTECT, sa, {3'b000, 8'h00});
    run(FBMC_OP_ID_READ, sa + 2, {3'b100, 8'h00});
    run(FBMC_OP_RESET, 0, {3'b010, 8'h00});
    busy_req = 1'b1;
    repeat (3) @(negedge clk);
    t0 = $time;
    run(FBMC_OP_RESET, 0, {3'b011, 8'h00});
    waited = ($time - t0) inside {[850:1400]};
    check("busy wait", 8'h01, {7'h00, waited});
    busy_req = 1'b0;
    run(FBMC_OP_WRITE, a, {3'b000, ~d});
    run(FBMC_OP_READ, a, {3'b100, ~d});
    report_and_stop();
  end
endmodule
`default_nettype wire
